// file: inc/tsmc_conv_if.sv
`timescale 1ns/100ps
interface tsmc_conv_if;
  logic standby;
  logic oneshot;
  logic out_of_range;
  logic busy;

  modport ctl(
    output standby,
    output oneshot,
    input out_of_range,
    input busy
  );

  modport seq(
    input standby,
    input oneshot,
    output out_of_range,
    output busy
  );
endinterface

// file: inc/tsmc_pkg.sv
package tsmc_pkg;

  typedef enum logic [9:0] {
    SMB_IDLE  = 10'h001,
    SMB_ADDR  = 10'h002,
    SMB_ACK_A = 10'h004,
    SMB_CMD   = 10'h008,
    SMB_ACK_C = 10'h010,
    SMB_WDATA = 10'h020,
    SMB_ACK_W = 10'h040,
    SMB_HOLD  = 10'h080,
    SMB_RDATA = 10'h100,
    SMB_RACK  = 10'h200
  } tsmc_smb_st_t;

  typedef enum logic [2:0] {
    CNV_IDLE = 3'h1,
    CNV_AUTO = 3'h2,
    CNV_SHOT = 3'h4
  } tsmc_cnv_st_t;

endpackage

// file: inc/tsmc_regs.svh
`ifndef TSMC_REGS_SVH
`define TSMC_REGS_SVH

// Fixed seven-bit bus address 1001110
`define TSMC_SMB_ADDR 7'h4e

// Command codes
`define TSMC_CMD_CFG_RD 8'h03
`define TSMC_CMD_CFG_WR 8'h09
`define TSMC_CMD_ONESHOT 8'h0f

// Configuration register layout
`define TSMC_CFG_MASK_BIT 7
`define TSMC_CFG_STBY_BIT 6
`define TSMC_CFG_RSVD_VAL 6'h00
`define TSMC_CFG_MASK_RST 1'b0
`define TSMC_CFG_STBY_RST 1'b0

// Byte framing
`define TSMC_BYTE_BITS 4'h8
`define TSMC_LAST_TX 4'h7
`define TSMC_CNT_ZERO 4'h0
`define TSMC_CNT_ONE 4'h1
`define TSMC_BYTE_ZERO 8'h00

`endif

// file: src/tsmc_conv_seq.sv
`timescale 1ns/100ps
`include "tsmc_regs.svh"
module tsmc_conv_seq
  import tsmc_pkg::*;
#(
  parameter int TEMP_W = 8
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  tsmc_conv_if.seq cif,
  input wire logic i_conv_done,
  input wire logic signed [TEMP_W-1:0] i_temp_remote,
  input wire logic signed [TEMP_W-1:0] i_temp_local,
  input wire logic signed [TEMP_W-1:0] i_thr_high,
  input wire logic signed [TEMP_W-1:0] i_thr_low,
  output logic o_conv_run
);

  generate
    if (TEMP_W < 2)
    begin : g_bad_width
      $error("TEMP_W must be at least 2");
    end
  endgenerate

  tsmc_cnv_st_t st_ff;
  tsmc_cnv_st_t nxt_st;
  logic run_ff;
  logic nxt_run;
  logic oor_ff;
  logic nxt_oor;

  // Equality counts as inside; alert only strictly beyond a threshold
  function automatic logic outside(
    input logic signed [TEMP_W-1:0] t,
    input logic signed [TEMP_W-1:0] hi,
    input logic signed [TEMP_W-1:0] lo
  );
    return (t > hi) || (t < lo);
  endfunction

  always_comb
  begin
    nxt_st = st_ff;
    nxt_oor = oor_ff;
    case (st_ff)
      CNV_IDLE:
      begin
        if (!cif.standby)
          nxt_st = CNV_AUTO;
        else if (cif.oneshot)
          nxt_st = CNV_SHOT;
      end
      CNV_AUTO:
      begin
        // One-shot ignored here, its result is not promised
        if (cif.standby)
          nxt_st = CNV_IDLE;
        else if (i_conv_done)
          nxt_oor = outside(i_temp_remote, i_thr_high, i_thr_low)
                    || outside(i_temp_local, i_thr_high, i_thr_low);
      end
      CNV_SHOT:
      begin
        if (i_conv_done)
        begin
          nxt_oor = outside(i_temp_remote, i_thr_high, i_thr_low)
                    || outside(i_temp_local, i_thr_high, i_thr_low);
          nxt_st = cif.standby ? CNV_IDLE : CNV_AUTO;
        end
        else if (!cif.standby)
          nxt_st = CNV_AUTO;
      end
      default:
        nxt_st = CNV_IDLE;
    endcase
    // Run drops in the same edge the state leaves, so a stop is immediate
    nxt_run = (nxt_st != CNV_IDLE);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_ff <= CNV_IDLE;
      run_ff <= 1'b0;
      oor_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      run_ff <= nxt_run;
      oor_ff <= nxt_oor;
    end
  end

  assign o_conv_run = run_ff;
  assign cif.out_of_range = oor_ff;
  assign cif.busy = (st_ff == CNV_SHOT);

endmodule

// file: src/tsmc_top.sv
// What this block does
// - Answers bus accesses only at the fixed seven-bit address 1001110.
// - Standby bit zero keeps the sensor converting continuously.
// - Writing standby bit one stops continuous conversion at once; a running one-shot waits for its conversion to finish.
// - In standby, a one-shot command runs exactly one conversion; one sent while a one-shot is busy is dropped.
// - Mask bit one keeps the alert output released.
// - Host writes reserved bits as zero; device reads them back as zero.
// - After reset mask and standby read zero: converting, alert unmasked.
// - Alert asserts when either temperature lies beyond either threshold.
`timescale 1ns/100ps
`include "tsmc_regs.svh"
module tsmc_top
  import tsmc_pkg::*;
#(
  parameter int TEMP_W = 8
)
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_SCL,
  input wire logic I_SDA,
  output logic O_SDA,
  output logic O_SDA_OE,
  output logic O_ALERT_N,
  output logic O_ALERT_OE,
  input wire logic I_CONV_DONE,
  input wire logic signed [TEMP_W-1:0] I_TEMP_REMOTE,
  input wire logic signed [TEMP_W-1:0] I_TEMP_LOCAL,
  input wire logic signed [TEMP_W-1:0] I_THR_HIGH,
  input wire logic signed [TEMP_W-1:0] I_THR_LOW,
  output logic O_CONV_RUN
);

  tsmc_conv_if cif();

  // Pin history for edge and start/stop detection
  logic scl_q_ff;
  logic sda_q_ff;
  logic nxt_scl_q;
  logic nxt_sda_q;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  // Byte engine
  tsmc_smb_st_t st_ff;
  tsmc_smb_st_t nxt_st;
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic [7:0] sh_ff;
  logic [7:0] nxt_sh;
  logic [7:0] cmd_ff;
  logic [7:0] nxt_cmd;
  logic [7:0] wdata_ff;
  logic [7:0] nxt_wdata;
  logic rw_ff;
  logic nxt_rw;
  logic nack_ff;
  logic nxt_nack;
  logic sda_oe_ff;
  logic nxt_sda_oe;
  logic shot_ff;
  logic nxt_shot;
  logic [7:0] rd_byte;

  // Configuration and alert
  logic mask_ff;
  logic nxt_mask;
  logic stby_ff;
  logic nxt_stby;
  logic alert_oe_ff;
  logic nxt_alert_oe;
  logic wr_commit;

  function automatic logic [7:0] read_mux(
    input logic [7:0] cmd,
    input logic mask,
    input logic stby
  );
    logic [7:0] r;
    r = `TSMC_BYTE_ZERO;
    if (cmd == `TSMC_CMD_CFG_RD)
    begin
      r[`TSMC_CFG_MASK_BIT] = mask;
      r[`TSMC_CFG_STBY_BIT] = stby;
      r[5:0] = `TSMC_CFG_RSVD_VAL;
    end
    return r;
  endfunction

  always_comb
  begin
    nxt_scl_q = I_SCL;
    nxt_sda_q = I_SDA;
  end

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end
    else
    begin
      scl_q_ff <= nxt_scl_q;
      sda_q_ff <= nxt_sda_q;
    end
  end

  assign scl_rise = I_SCL & ~scl_q_ff;
  assign scl_fall = ~I_SCL & scl_q_ff;
  assign bus_start = I_SCL & scl_q_ff & sda_q_ff & ~I_SDA;
  assign bus_stop = I_SCL & scl_q_ff & ~sda_q_ff & I_SDA;
  assign rd_byte = read_mux(cmd_ff, mask_ff, stby_ff);

  // Data changes on the first clock after SCL falls; hold time is at most one clock period
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_cmd = cmd_ff;
    nxt_wdata = wdata_ff;
    nxt_rw = rw_ff;
    nxt_nack = nack_ff;
    nxt_sda_oe = sda_oe_ff;
    nxt_shot = 1'b0;
    if (bus_start)
    begin
      nxt_st = SMB_ADDR;
      nxt_cnt = `TSMC_CNT_ZERO;
      nxt_sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      nxt_st = SMB_IDLE;
      nxt_sda_oe = 1'b0;
    end
    else
    begin
      case (st_ff)
        SMB_ADDR, SMB_CMD, SMB_WDATA:
        begin
          if (scl_rise && cnt_ff != `TSMC_BYTE_BITS)
          begin
            nxt_sh = {sh_ff[6:0], I_SDA};
            nxt_cnt = cnt_ff + `TSMC_CNT_ONE;
          end
          else if (scl_fall && cnt_ff == `TSMC_BYTE_BITS)
          begin
            nxt_sda_oe = 1'b1;
            if (st_ff == SMB_ADDR)
            begin
              if (sh_ff[7:1] == `TSMC_SMB_ADDR)
              begin
                nxt_rw = sh_ff[0];
                nxt_st = SMB_ACK_A;
              end
              else
              begin
                // Other addresses: stay off the bus until the next start
                nxt_sda_oe = 1'b0;
                nxt_st = SMB_IDLE;
              end
            end
            else if (st_ff == SMB_CMD)
            begin
              nxt_cmd = sh_ff;
              nxt_st = SMB_ACK_C;
            end
            else
            begin
              nxt_wdata = sh_ff;
              nxt_st = SMB_ACK_W;
            end
          end
        end
        SMB_ACK_A:
        begin
          if (scl_fall)
          begin
            nxt_cnt = `TSMC_CNT_ZERO;
            if (rw_ff)
            begin
              nxt_sh = rd_byte;
              nxt_sda_oe = ~rd_byte[7];
              nxt_st = SMB_RDATA;
            end
            else
            begin
              nxt_sda_oe = 1'b0;
              nxt_st = SMB_CMD;
            end
          end
        end
        SMB_ACK_C:
        begin
          if (scl_fall)
          begin
            nxt_sda_oe = 1'b0;
            nxt_cnt = `TSMC_CNT_ZERO;
            nxt_shot = (cmd_ff == `TSMC_CMD_ONESHOT) && !cif.busy;
            nxt_st = SMB_WDATA;
          end
        end
        SMB_ACK_W:
        begin
          if (scl_fall)
          begin
            nxt_sda_oe = 1'b0;
            nxt_st = SMB_HOLD;
          end
        end
        SMB_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_ff == `TSMC_LAST_TX)
            begin
              nxt_sda_oe = 1'b0;
              nxt_st = SMB_RACK;
            end
            else
            begin
              nxt_sh = {sh_ff[6:0], 1'b0};
              nxt_sda_oe = ~sh_ff[6];
              nxt_cnt = cnt_ff + `TSMC_CNT_ONE;
            end
          end
        end
        SMB_RACK:
        begin
          if (scl_rise)
            nxt_nack = I_SDA;
          else if (scl_fall)
          begin
            if (nack_ff)
              nxt_st = SMB_IDLE;
            else
            begin
              nxt_sh = rd_byte;
              nxt_sda_oe = ~rd_byte[7];
              nxt_cnt = `TSMC_CNT_ZERO;
              nxt_st = SMB_RDATA;
            end
          end
        end
        SMB_HOLD, SMB_IDLE:
          nxt_st = st_ff;
        default:
          nxt_st = SMB_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      st_ff <= SMB_IDLE;
      cnt_ff <= `TSMC_CNT_ZERO;
      sh_ff <= `TSMC_BYTE_ZERO;
      cmd_ff <= `TSMC_BYTE_ZERO;
      wdata_ff <= `TSMC_BYTE_ZERO;
      rw_ff <= 1'b0;
      nack_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      shot_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      cmd_ff <= nxt_cmd;
      wdata_ff <= nxt_wdata;
      rw_ff <= nxt_rw;
      nack_ff <= nxt_nack;
      sda_oe_ff <= nxt_sda_oe;
      shot_ff <= nxt_shot;
    end
  end

  // A write only lands on the stop, never on an aborted transfer
  assign wr_commit = bus_stop && (st_ff == SMB_HOLD) && (cmd_ff == `TSMC_CMD_CFG_WR);

  always_comb
  begin
    nxt_mask = mask_ff;
    nxt_stby = stby_ff;
    if (wr_commit)
    begin
      nxt_mask = wdata_ff[`TSMC_CFG_MASK_BIT];
      nxt_stby = wdata_ff[`TSMC_CFG_STBY_BIT];
    end
    nxt_alert_oe = cif.out_of_range & ~mask_ff;
  end

  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      mask_ff <= `TSMC_CFG_MASK_RST;
      stby_ff <= `TSMC_CFG_STBY_RST;
      alert_oe_ff <= 1'b0;
    end
    else
    begin
      mask_ff <= nxt_mask;
      stby_ff <= nxt_stby;
      alert_oe_ff <= nxt_alert_oe;
    end
  end

  assign cif.standby = stby_ff;
  assign cif.oneshot = shot_ff;

  tsmc_conv_seq #(
    .TEMP_W(TEMP_W)
  ) u_seq (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .cif(cif),
    .i_conv_done(I_CONV_DONE),
    .i_temp_remote(I_TEMP_REMOTE),
    .i_temp_local(I_TEMP_LOCAL),
    .i_thr_high(I_THR_HIGH),
    .i_thr_low(I_THR_LOW),
    .o_conv_run(O_CONV_RUN)
  );

  // Open-drain pins only ever pull low
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_SDA <= 1'b0;
      O_ALERT_N <= 1'b0;
    end
    else
    begin
      O_SDA <= 1'b0;
      O_ALERT_N <= 1'b0;
    end
  end

  assign O_SDA_OE = sda_oe_ff;
  assign O_ALERT_OE = alert_oe_ff;

endmodule

// file: test/tsmc_smb_host.sv
`timescale 1ns/100ps
`include "tsmc_regs.svh"
module tsmc_smb_host
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Four clocks per phase, above the one the device needs
  task automatic step(input logic c, input logic d);
    o_scl = c;
    o_sda = d;
    repeat (4) @(negedge i_clk);
  endtask
  // Clock drops before data moves, so no false start or stop
  task automatic bit_io(input logic b, output logic got);
    step(1'b0, o_sda);
    step(1'b0, b);
    step(1'b1, b);
    got = i_sda;
  endtask
  task automatic start();
    step(1'b0, o_sda);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask
  task automatic stop();
    step(1'b0, o_sda);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q, output logic nak);
    logic g;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], g);
      q = {q[6:0], g};
    end
    bit_io(1'b1, nak);
  endtask
  // Byte write, or send byte when no data follows
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
    input logic has_d, output logic nak);
    logic [7:0] q;
    logic n;
    start();
    byte_io({a, 1'b0}, q, nak);
    byte_io(c, q, n);
    nak = nak | n;
    if (has_d)
    begin
      byte_io(d, q, n);
      nak = nak | n;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    logic n;
    start();
    byte_io({`TSMC_SMB_ADDR, 1'b0}, d, n);
    byte_io(c, d, n);
    start();
    byte_io({`TSMC_SMB_ADDR, 1'b1}, d, n);
    byte_io(8'hff, d, n);
    stop();
  endtask
  // Host acks the first byte, so the device sends it again
  task automatic rd2(input logic [7:0] c, output logic [7:0] d0, output logic [7:0] d1);
    logic n;
    logic g;
    start();
    byte_io({`TSMC_SMB_ADDR, 1'b0}, d0, n);
    byte_io(c, d0, n);
    start();
    byte_io({`TSMC_SMB_ADDR, 1'b1}, d0, n);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, g);
      d0 = {d0[6:0], g};
    end
    bit_io(1'b0, n);
    byte_io(8'hff, d1, n);
    stop();
  endtask
endmodule

// file: test/tsmc_top_monitor.sv
`timescale 1ns/100ps
module tsmc_top_monitor
#(
  parameter int TEMP_W = 8
)
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_SCL,
  input wire logic I_SDA,
  input wire logic O_SDA,
  input wire logic O_SDA_OE,
  input wire logic O_ALERT_N,
  input wire logic O_ALERT_OE,
  input wire logic I_CONV_DONE,
  input wire logic signed [TEMP_W-1:0] I_TEMP_REMOTE,
  input wire logic signed [TEMP_W-1:0] I_TEMP_LOCAL,
  input wire logic signed [TEMP_W-1:0] I_THR_HIGH,
  input wire logic signed [TEMP_W-1:0] I_THR_LOW,
  input wire logic O_CONV_RUN
);
  logic scl_ff;
  logic sda_ff;
  logic [2:0] since_stop_ff;
  logic [2:0] nxt_since_stop;
  logic near_stop;
  logic out_rng;
  logic hot;
  logic cool;
  assign out_rng = I_TEMP_REMOTE > I_THR_HIGH || I_TEMP_REMOTE < I_THR_LOW
    || I_TEMP_LOCAL > I_THR_HIGH || I_TEMP_LOCAL < I_THR_LOW;
  assign hot = I_CONV_DONE && O_CONV_RUN && out_rng;
  assign cool = I_CONV_DONE && O_CONV_RUN && !out_rng;
  // Mask and standby land a few cycles after a stop, inside a fixed six-cycle window sized for the one-flop pin sync
  assign near_stop = since_stop_ff < 3'h6;
  always_comb
  begin
    nxt_since_stop = since_stop_ff + {2'h0, since_stop_ff != 3'h7};
    if (scl_ff && I_SCL && !sda_ff && I_SDA)
    begin
      nxt_since_stop = 3'h0;
    end
  end
  always_ff @(posedge I_CLOCK or posedge I_RST)
  begin
    if (I_RST)
    begin
      scl_ff <= 1'b1;
      sda_ff <= 1'b1;
      since_stop_ff <= 3'h7;
    end
    else
    begin
      scl_ff <= I_SCL;
      sda_ff <= I_SDA;
      since_stop_ff <= nxt_since_stop;
    end
  end
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  AST_RST_QUIET: assert property ($fell(I_RST) |-> !(O_SDA_OE || O_ALERT_OE || O_CONV_RUN))
    else $error("outputs busy at reset release");
  AST_AUTO_START: assert property ($fell(I_RST) |-> ##[1:2] O_CONV_RUN)
    else $error("no conversion after reset");
  AST_PINS_LOW: assert property (!O_SDA && !O_ALERT_N)
    else $error("open drain value not low");
  AST_SDA_SCL_LOW: assert property ($changed(O_SDA_OE) |-> !I_SCL && !$past(I_SCL))
    else $error("data moved with clock high");
  AST_RUN_FALL: assert property ($fell(O_CONV_RUN) |-> $past(I_CONV_DONE)
    || $past(I_CONV_DONE, 2) || near_stop) else $error("conversion stopped without cause");
  AST_ALERT_RISE: assert property ($rose(O_ALERT_OE) |-> $past(hot, 2) || $past(hot, 3)
    || near_stop) else $error("alert raised without cause");
  AST_ALERT_FALL: assert property ($fell(O_ALERT_OE) |-> $past(cool, 2) || $past(cool, 3)
    || near_stop) else $error("alert dropped without cause");
  AST_IN_RANGE: assert property (cool |-> ##3 !O_ALERT_OE)
    else $error("alert held after in range reading");
  cover property ($rose(O_ALERT_OE));
  cover property ($fell(O_CONV_RUN));
  cover property ($rose(O_SDA_OE));
endmodule
bind tsmc_top tsmc_top_monitor #(.TEMP_W(TEMP_W)) u_monitor (.I_CLOCK(I_CLOCK), .I_RST(I_RST),
  .I_SCL(I_SCL), .I_SDA(I_SDA), .O_SDA(O_SDA), .O_SDA_OE(O_SDA_OE), .O_ALERT_N(O_ALERT_N),
  .O_ALERT_OE(O_ALERT_OE), .I_CONV_DONE(I_CONV_DONE), .I_TEMP_REMOTE(I_TEMP_REMOTE),
  .I_TEMP_LOCAL(I_TEMP_LOCAL), .I_THR_HIGH(I_THR_HIGH), .I_THR_LOW(I_THR_LOW),
  .O_CONV_RUN(O_CONV_RUN));

// file: test/tsmc_top_test.sv
`timescale 1ns/100ps
`include "tsmc_regs.svh"
module tsmc_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic done = 1'b0;
  logic signed [7:0] t_rem = 8'sh00;
  logic signed [7:0] t_loc = 8'sh00;
  logic signed [7:0] thr_hi = 8'sh32;
  logic signed [7:0] thr_lo = 8'shf6;
  logic scl;
  logic sda_h;
  logic sda_w;
  logic sda_oe;
  logic alert_oe;
  logic run;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  // Pull-up wins unless a party pulls low
  assign sda_w = sda_h & ~sda_oe;
  always #10 clk = ~clk;
  tsmc_top #(.TEMP_W(8)) u_dut (.I_CLOCK(clk), .I_RST(rst), .I_SCL(scl), .I_SDA(sda_w),
    .O_SDA(), .O_SDA_OE(sda_oe), .O_ALERT_N(), .O_ALERT_OE(alert_oe), .I_CONV_DONE(done),
    .I_TEMP_REMOTE(t_rem), .I_TEMP_LOCAL(t_loc), .I_THR_HIGH(thr_hi), .I_THR_LOW(thr_lo),
    .O_CONV_RUN(run));
  tsmc_smb_host u_host (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(sda_h));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
    begin
      $display("All checks passed");
    end
    else
    begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic convert(input logic [7:0] r, input logic [7:0] l);
    @(negedge clk);
    t_rem = r;
    t_loc = l;
    done = 1'b1;
    @(negedge clk);
    done = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic cfg_wr(input logic [7:0] d);
    logic n;
    u_host.wr(`TSMC_SMB_ADDR, `TSMC_CMD_CFG_WR, d, 1'b1, n);
    check(8'(n), 8'h00);
  endtask
  task automatic t_reset();
    logic [7:0] d;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check(8'(run), 8'h01);
    check(8'(alert_oe), 8'h00);
    u_host.rd(`TSMC_CMD_CFG_RD, d);
    check(d & 8'hc0, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_address();
    logic n;
    logic [7:0] d;
    u_host.wr(7'h4f, `TSMC_CMD_CFG_WR, 8'h40, 1'b1, n);
    check(8'(n), 8'h01);
    check(8'(run), 8'h01);
    u_host.rd(`TSMC_CMD_CFG_RD, d);
    check(d & 8'hc0, 8'h00);
    u_host.rd(8'h55, d);
    check(d, 8'h00);
    $display("address test done");
  endtask
  task automatic t_alert();
    convert(8'sh3c, 8'sh14);
    check(8'(alert_oe), 8'h01);
    convert(8'sh32, 8'shf6);
    check(8'(alert_oe), 8'h00);
    convert(8'sh14, 8'she2);
    check(8'(alert_oe), 8'h01);
    cfg_wr(8'h80);
    check(8'(alert_oe), 8'h00);
    convert(8'sh3c, 8'sh14);
    check(8'(alert_oe), 8'h00);
    cfg_wr(8'h00);
    check(8'(alert_oe), 8'h01);
    convert(8'sh00, 8'sh00);
    check(8'(alert_oe), 8'h00);
    thr_hi = 8'sh0a;
    convert(8'sh14, 8'sh00);
    check(8'(alert_oe), 8'h01);
    thr_hi = 8'sh32;
    convert(8'sh14, 8'sh00);
    check(8'(alert_oe), 8'h00);
    $display("alert test done");
  endtask
  task automatic t_standby();
    logic n;
    logic [7:0] d;
    logic [7:0] d2;
    cfg_wr(8'h40);
    check(8'(run), 8'h00);
    u_host.rd(`TSMC_CMD_CFG_RD, d);
    check(d & 8'hc0, 8'h40);
    u_host.rd2(`TSMC_CMD_CFG_RD, d, d2);
    check(d & 8'hc0, 8'h40);
    check(d2 & 8'hc0, 8'h40);
    // One-shot only in standby, where its result counts
    u_host.wr(`TSMC_SMB_ADDR, `TSMC_CMD_ONESHOT, 8'h00, 1'b0, n);
    check(8'(run), 8'h01);
    convert(8'sh3c, 8'sh14);
    check(8'(run), 8'h00);
    check(8'(alert_oe), 8'h01);
    cfg_wr(8'hc0);
    check(8'(alert_oe), 8'h00);
    $display("standby test done");
  endtask
  initial
  begin
    t_reset();
    t_address();
    t_alert();
    t_standby();
    t_reset();
    tally_and_finish();
  end
endmodule
